// *** core/quad_timer_unit.sv ***
// Four counter/timers with a register port, sticky flags and an interrupt output.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "quad_timer_map.svh"
module quad_timer_unit (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          srst,
    // Event and oscillator pins
    input  wire logic          event_input_zero,
    input  wire logic          event_input_one,
    input  wire logic          ext_osc_clk,
    // Register port
    input  qt_pkg::reg_addr_type addr,
    input  qt_pkg::byte_type   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output qt_pkg::byte_type   rdata,
    // Interrupt and timebase ticks
    output logic               irq,
    output logic [1:0]         timebase_tick
);
    import qt_pkg::*;

    timer_state_type s_q;
    timer_state_type s_d;
    tick_if          ticks ();
    legacy_mode_type m0;
    legacy_mode_type m1;
    logic [16:0]     step0;
    logic [16:0]     step1;
    logic [1:0]      tsel_tick;
    logic [1:0]      cnt_tick;
    logic [1:0]      lo_tick;
    logic [1:0]      hi_tick;
    logic [8:0]      bstep;
    logic [5:0]      set_flags;
    logic [5:0]      clr_flags;

    // Returns the overflow bit and the next count of timer 0 or 1.
    function automatic logic [16:0] legacy_step(input legacy_mode_type m, input logic [15:0] c);
        logic [12:0] v;
        logic        o;
        logic [15:0] n;
        v = {c[15:8], c[4:0]} + 13'h0001;
        o = 1'b0;
        n = c;
        case (m)
            MODE13: begin
                // Bits 7 to 5 of the low byte are left alone; they hold no count.
                o = &{c[15:8], c[4:0]};
                n = {v[12:5], c[7:5], v[4:0]};
            end
            MODE16: begin
                o = &c;
                n = c + 16'h0001;
            end
            MODE8RL: begin
                o = &c[7:0];
                n = {c[15:8], o ? c[15:8] : c[7:0] + 8'h01};
            end
            default: begin
                o = &c[7:0];
                n = {c[15:8], c[7:0] + 8'h01};
            end
        endcase
        return {o, n};
    endfunction

    // Returns the overflow bit and the next value of an 8-bit reload timer.
    function automatic logic [8:0] byte_step(input logic [7:0] c, input logic [7:0] r);
        return {&c, (&c) ? r : c + 8'h01};
    endfunction

    tick_source u_ticks (
        .clk              (clk),
        .srst             (srst),
        .event_input_zero (event_input_zero),
        .event_input_one  (event_input_one),
        .ext_osc_clk      (ext_osc_clk),
        .tk               (ticks)
    );

    assign ticks.prescale_field = s_q.clock_sel[1:0];
    assign m0 = legacy_mode_type'(s_q.mode[1:0]);
    assign m1 = legacy_mode_type'(s_q.mode[`QT_MD_T1 +: 2]);
    assign step0 = legacy_step(m0, s_q.count[0]);
    assign step1 = legacy_step(m1, s_q.count[1]);

    always_comb begin
        s_d = s_q;
        set_flags = 6'h00;
        clr_flags = 6'h00;
        bstep = 9'h000;
        tsel_tick = 2'h0;
        cnt_tick = 2'h0;
        lo_tick = 2'h0;
        hi_tick = 2'h0;
        for (int i = 0; i < 2; i++) begin
            tsel_tick[i] = s_q.clock_sel[`QT_CS_T0 + i] | ticks.presc;
            // In counter operation the clock select has no effect.
            cnt_tick[i] = s_q.mode[`QT_MD_CT0 + 4 * i] ? ticks.fall[i] : tsel_tick[i];
        end
        // Timer 0, or its low byte when split.
        if (s_q.run[`QT_RN_T0] && cnt_tick[0]) begin
            s_d.count[0] = step0[15:0];
            set_flags[`QT_FL_T0] = step0[16];
        end
        // Split timer 0 lends its high byte the run bit and flag of timer 1.
        if (m0 == MODE_SPLIT && s_q.run[`QT_RN_T1] && tsel_tick[0]) begin
            s_d.count[0][15:8] = s_q.count[0][15:8] + 8'h01;
            set_flags[`QT_FL_T1] = &s_q.count[0][15:8];
        end
        // Timer 1 holds in split mode; it keeps counting but flags nothing while timer 0 is split.
        if (m1 != MODE_SPLIT && s_q.run[`QT_RN_T1] && cnt_tick[1]) begin
            s_d.count[1] = step1[15:0];
            if (m0 != MODE_SPLIT) begin
                set_flags[`QT_FL_T1] = step1[16];
            end
        end
        // Timers 2 and 3.
        for (int i = 0; i < 2; i++) begin
            lo_tick[i] = s_q.clock_sel[`QT_CS_T2L + 2 * i]
                | (s_q.run[`QT_RN_XCLK2 + i] ? ticks.ext8 : ticks.div12);
            hi_tick[i] = s_q.clock_sel[`QT_CS_T2H + 2 * i]
                | (s_q.run[`QT_RN_XCLK2 + i] ? ticks.ext8 : ticks.div12);
            if (s_q.run[`QT_RN_T2 + i]) begin
                if (s_q.run[`QT_RN_SPLIT2 + i]) begin
                    if (lo_tick[i]) begin
                        bstep = byte_step(s_q.count[2 + i][7:0], s_q.reload[i][7:0]);
                        s_d.count[2 + i][7:0] = bstep[7:0];
                        set_flags[`QT_FL_T2L + 2 * i] = bstep[8];
                    end
                    if (hi_tick[i]) begin
                        bstep = byte_step(s_q.count[2 + i][15:8], s_q.reload[i][15:8]);
                        s_d.count[2 + i][15:8] = bstep[7:0];
                        set_flags[`QT_FL_T2H + 2 * i] = bstep[8];
                    end
                end else if (lo_tick[i]) begin
                    s_d.count[2 + i] = (&s_q.count[2 + i]) ? s_q.reload[i]
                        : s_q.count[2 + i] + 16'h0001;
                    set_flags[`QT_FL_T2H + 2 * i] = &s_q.count[2 + i];
                end
            end
            // Other blocks may use the high-byte overflow as a timebase.
            s_d.tick[i] = set_flags[`QT_FL_T2H + 2 * i];
        end
        // A software write lands after the count, so it wins in the same cycle.
        if (wr) begin
            case (addr)
                `QT_REG_CLKSEL: s_d.clock_sel = wdata;
                `QT_REG_MODE: s_d.mode = wdata;
                `QT_REG_RUN: s_d.run = wdata;
                `QT_REG_T0L: s_d.count[0][7:0] = wdata;
                `QT_REG_T0H: s_d.count[0][15:8] = wdata;
                `QT_REG_T1L: s_d.count[1][7:0] = wdata;
                `QT_REG_T1H: s_d.count[1][15:8] = wdata;
                `QT_REG_T2L: s_d.count[2][7:0] = wdata;
                `QT_REG_T2H: s_d.count[2][15:8] = wdata;
                `QT_REG_R2L: s_d.reload[0][7:0] = wdata;
                `QT_REG_R2H: s_d.reload[0][15:8] = wdata;
                `QT_REG_T3L: s_d.count[3][7:0] = wdata;
                `QT_REG_T3H: s_d.count[3][15:8] = wdata;
                `QT_REG_R3L: s_d.reload[1][7:0] = wdata;
                `QT_REG_R3H: s_d.reload[1][15:8] = wdata;
                `QT_REG_STATUS: clr_flags = wdata[5:0];
                `QT_REG_MASK: s_d.mask = wdata[5:0];
                default: ;
            endcase
        end
        // A flag raised in the cycle of its clear survives.
        s_d.status = (s_q.status & ~clr_flags) | set_flags;
        s_d.irq = |(s_d.status & s_d.mask);
        s_d.rdata = 8'h00;
        if (rd) begin
            case (addr)
                `QT_REG_CLKSEL: s_d.rdata = s_q.clock_sel;
                `QT_REG_MODE: s_d.rdata = s_q.mode;
                `QT_REG_RUN: s_d.rdata = s_q.run;
                `QT_REG_T0L: s_d.rdata = s_q.count[0][7:0];
                `QT_REG_T0H: s_d.rdata = s_q.count[0][15:8];
                `QT_REG_T1L: s_d.rdata = s_q.count[1][7:0];
                `QT_REG_T1H: s_d.rdata = s_q.count[1][15:8];
                `QT_REG_T2L: s_d.rdata = s_q.count[2][7:0];
                `QT_REG_T2H: s_d.rdata = s_q.count[2][15:8];
                `QT_REG_R2L: s_d.rdata = s_q.reload[0][7:0];
                `QT_REG_R2H: s_d.rdata = s_q.reload[0][15:8];
                `QT_REG_T3L: s_d.rdata = s_q.count[3][7:0];
                `QT_REG_T3H: s_d.rdata = s_q.count[3][15:8];
                `QT_REG_R3L: s_d.rdata = s_q.reload[1][7:0];
                `QT_REG_R3H: s_d.rdata = s_q.reload[1][15:8];
                `QT_REG_STATUS: s_d.rdata = {2'h0, s_q.status};
                `QT_REG_MASK: s_d.rdata = {2'h0, s_q.mask};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= `QT_RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign irq = s_q.irq;
    assign timebase_tick = s_q.tick;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // The level is checked against the flags and events one cycle earlier, not its own copy.
    a_irq_level: assert property (!wr
        |=> irq == $past(|((s_q.status | set_flags) & s_q.mask)))
        else $error("irq does not follow masked flags");
    a_flag_sticky: assert property (s_q.status[0]
        && !(wr && addr == `QT_REG_STATUS && wdata[0]) |=> s_q.status[0])
        else $error("flag lost without clear");
    a_flag_clear: assert property (wr && addr == `QT_REG_STATUS && wdata[0]
        && !set_flags[0] |=> !s_q.status[0])
        else $error("flag not cleared");
    a_mode13_wrap: assert property (s_q.run[0] && m0 == MODE13 && cnt_tick[0] && !wr
        && {s_q.count[0][15:8], s_q.count[0][4:0]} == 13'h1fff
        |=> s_q.status[0] && s_q.count[0][15:8] == 8'h00 && s_q.count[0][4:0] == 5'h00)
        else $error("13-bit wrap wrong");
    a_event_count: assert property (s_q.run[0] && s_q.mode[2] && m0 == MODE16
        && ticks.fall[0] && !wr |=> s_q.count[0] == $past(s_q.count[0]) + 16'h0001)
        else $error("event not counted");
    a_event_ignore: assert property (s_q.run[0] && s_q.mode[2] && m0 != MODE_SPLIT
        && !ticks.fall[0] && !wr |=> s_q.count[0] == $past(s_q.count[0]))
        else $error("counter moved without event");
    a_sysclk_rate: assert property ((s_q.run[0] && !s_q.mode[2] && s_q.clock_sel[2]
        && m0 == MODE16 && !wr) [*2] |=> s_q.count[0] == $past(s_q.count[0], 2) + 16'h0002)
        else $error("system clock rate wrong");
    a_t2_reload: assert property (s_q.run[2] && !s_q.run[4] && lo_tick[0]
        && &s_q.count[2] && !wr |=> s_q.count[2] == $past(s_q.reload[0]) && timebase_tick[0])
        else $error("timer 2 reload wrong");
endmodule

// *** core/tick_source.sv ***
// Pin synchronisers, edge detectors and clock dividers of the timer unit.
`timescale 1ns/1ps
`include "quad_timer_map.svh"
module tick_source (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Pins
    input  wire logic event_input_zero,
    input  wire logic event_input_one,
    input  wire logic ext_osc_clk,
    // Ticks
    tick_if.gen       tk
);
    import qt_pkg::*;
    tick_state_type t_q;
    tick_state_type t_d;
    logic           x_rise;

    always_comb begin
        t_d = t_q;
        x_rise = t_q.sync_x[1] & ~t_q.prev_x;
        t_d.sync_ev[0] = {t_q.sync_ev[0][0], event_input_zero};
        t_d.sync_ev[1] = {t_q.sync_ev[1][0], event_input_one};
        t_d.prev_ev = {t_q.sync_ev[1][1], t_q.sync_ev[0][1]};
        for (int i = 0; i < 2; i++) begin
            // Each level is seen in at least two samples, so no edge is missed.
            t_d.fall[i] = t_q.prev_ev[i] & ~t_q.sync_ev[i][1];
        end
        t_d.sync_x = {t_q.sync_x[0], ext_osc_clk};
        t_d.prev_x = t_q.sync_x[1];
        t_d.cnt_x = x_rise ? t_q.cnt_x + 3'h1 : t_q.cnt_x;
        t_d.ext8 = x_rise && t_q.cnt_x == 3'(`QT_DIV_EXT - 1);
        t_d.div12 = t_q.cnt12 == 4'(`QT_DIV_SLOW - 1);
        t_d.cnt12 = t_d.div12 ? 4'h0 : t_q.cnt12 + 4'h1;
        t_d.cnt4 = t_q.cnt4 + 2'h1;
        t_d.cnt48 = (t_q.cnt48 == 6'(`QT_DIV_SLOWEST - 1)) ? 6'h00 : t_q.cnt48 + 6'h01;
        case (tk.prescale_field)
            2'h0: t_d.presc = t_d.div12;
            2'h1: t_d.presc = t_q.cnt4 == 2'(`QT_DIV_FAST - 1);
            2'h2: t_d.presc = t_q.cnt48 == 6'(`QT_DIV_SLOWEST - 1);
            default: t_d.presc = t_d.ext8;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            t_q <= `QT_RST_STATE;
        end else begin
            t_q <= t_d;
        end
    end

    assign tk.fall = t_q.fall;
    assign tk.presc = t_q.presc;
    assign tk.div12 = t_q.div12;
    assign tk.ext8 = t_q.ext8;

    a_div12_period: assert property (@(posedge clk) disable iff (srst) t_q.div12 |-> ##12 t_q.div12) else $error("div12 period wrong");
    a_div12_quiet: assert property (@(posedge clk) disable iff (srst) t_q.div12 |=> !t_q.div12 [*8]) else $error("div12 too often");
    a_fall_pulse: assert property (@(posedge clk) disable iff (srst) $fell(t_q.sync_ev[0][1]) |=> t_q.fall[0] ##1 !t_q.fall[0]) else $error("falling edge missed");
endmodule

// *** shared/qt_pkg.sv ***
// Types shared by the timer unit and its tick source.
package qt_pkg;
    typedef logic [4:0] reg_addr_type;
    typedef logic [7:0] byte_type;
    typedef enum logic [1:0] {MODE13, MODE16, MODE8RL, MODE_SPLIT} legacy_mode_type;
    typedef struct packed {
        logic [7:0]       clock_sel;
        logic [7:0]       mode;
        logic [7:0]       run;
        logic [3:0][15:0] count;
        logic [1:0][15:0] reload;
        logic [5:0]       status;
        logic [5:0]       mask;
        logic [7:0]       rdata;
        logic             irq;
        logic [1:0]       tick;
    } timer_state_type;
    typedef struct packed {
        logic [1:0][1:0] sync_ev;
        logic [1:0]      prev_ev;
        logic [1:0]      sync_x;
        logic            prev_x;
        logic [3:0]      cnt12;
        logic [1:0]      cnt4;
        logic [5:0]      cnt48;
        logic [2:0]      cnt_x;
        logic [1:0]      fall;
        logic            presc;
        logic            div12;
        logic            ext8;
    } tick_state_type;
endpackage

// *** shared/quad_timer_map.svh ***
// Register offsets, field positions, reset values and divider counts of the timer unit.
// Notes on behaviour
// - Four 16-bit counter/timers; split timer 0 borrows timer 1's run bit and flag.
// - Timers 0/1 13/16-bit, 8-bit reload, split timer 0.
// - Timers 2/3: 16-bit or two 8-bit reload.
// - Timers 0/1 pick prescaled or system clock.
// - Timers 2/3: system, system/12, external/8.
// - Counter mode counts falling edges on event pin.
// - Counts events up to quarter system clock rate.
// - Overflows raise periodic interrupt requests.
// - Prescale field: /12, /4, /48, external/8.
// - Clock select one is system clock; counter ignores.
// - 13-bit wrap 0x1FFF to 0 sets flag.
// - Timers 2/3 per-byte clock select.
`ifndef QUAD_TIMER_MAP_SVH
`define QUAD_TIMER_MAP_SVH
`define QT_REG_CLKSEL 5'h00
`define QT_REG_MODE   5'h01
`define QT_REG_RUN    5'h02
`define QT_REG_T0L    5'h03
`define QT_REG_T0H    5'h04
`define QT_REG_T1L    5'h05
`define QT_REG_T1H    5'h06
`define QT_REG_T2L    5'h07
`define QT_REG_T2H    5'h08
`define QT_REG_R2L    5'h09
`define QT_REG_R2H    5'h0a
`define QT_REG_T3L    5'h0b
`define QT_REG_T3H    5'h0c
`define QT_REG_R3L    5'h0d
`define QT_REG_R3H    5'h0e
`define QT_REG_STATUS 5'h0f
`define QT_REG_MASK   5'h10
`define QT_CS_T0      2
`define QT_CS_T2L     4
`define QT_CS_T2H     5
`define QT_MD_CT0     2
`define QT_MD_T1      4
`define QT_RN_T0      0
`define QT_RN_T1      1
`define QT_RN_T2      2
`define QT_RN_SPLIT2  4
`define QT_RN_XCLK2   6
`define QT_FL_T0      0
`define QT_FL_T1      1
`define QT_FL_T2L     2
`define QT_FL_T2H     3
`define QT_RST_STATE  '0
`define QT_DIV_SLOW   12
`define QT_DIV_FAST   4
`define QT_DIV_SLOWEST 48
`define QT_DIV_EXT    8
`endif

// *** shared/tick_if.sv ***
// Tick and edge pulses passed from the tick source to the timer unit.
`timescale 1ns/1ps
interface tick_if;
    logic [1:0] prescale_field;
    logic [1:0] fall;
    logic       presc;
    logic       div12;
    logic       ext8;
    modport gen (input prescale_field, output fall, presc, div12, ext8);
    modport sink (output prescale_field, input fall, presc, div12, ext8);
endinterface

// *** verif/event_source.sv ***
// External event pins and free-running oscillator that sit outside the timer unit.
`timescale 1ns/1ps
module event_source (
    // Clock
    input  wire logic       clk,
    // Pins
    output logic      [1:0] ev,
    output logic            osc
);
    initial begin
        ev  = 2'h3;
        osc = 1'b0;
        // The oscillator runs free at clk/8, well below the clk/4 limit, and out of phase.
        #1.3;
        forever #20 osc = ~osc;
    end

    // Each level is held exactly two clocks, the fastest event rate the counter must catch.
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge clk);
            ev[idx] <= 1'b0;
            repeat (2) @(posedge clk);
            ev[idx] <= 1'b1;
            @(posedge clk);
        end
    endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench of the quad timer unit against a small behavioural model.
`timescale 1ns/1ps
`define CHK(g, e) check(16'(g), 16'(e))
module tb;
    import qt_pkg::*;
    logic         clk;
    logic         srst;
    logic         wr;
    logic         rd;
    reg_addr_type addr;
    byte_type     wdata;
    byte_type     rdata;
    logic         irq;
    logic [1:0]   timebase_tick;
    logic [1:0]   ev;
    logic         osc;
    byte_type     d;
    byte_type     lo;
    byte_type     hi;
    int           fail_count;
    int           cmp_count;
    int           model_reg [0:31];
    int           n;
    int           v;
    int           e;
    int           r;
    int           ovf;
    int           ra [4] = '{0, 1, 16, 17};
    int           rm [4] = '{'hff, 'h77, 'h3f, 0};
    int           pdiv [5] = '{12, 4, 48, 64, 1};
    int           tdiv [4] = '{1, 12, 64, 1};
    int           sinit [4] = '{'hf0, 'h20, 'hf0, 'hff};

    quad_timer_unit quad_timer_unit_i (
        .clk              (clk),
        .srst             (srst),
        .event_input_zero (ev[0]),
        .event_input_one  (ev[1]),
        .ext_osc_clk      (osc),
        .addr             (addr),
        .wdata            (wdata),
        .wr               (wr),
        .rd               (rd),
        .rdata            (rdata),
        .irq              (irq),
        .timebase_tick    (timebase_tick)
    );
    event_source ev_i (
        .clk (clk),
        .ev  (ev),
        .osc (osc)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] g, input logic [15:0] x);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic finish_test;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr_reg(input int a, input int x);
        @(posedge clk);
        addr  <= reg_addr_type'(a);
        wdata <= byte_type'(x);
        wr    <= 1'b1;
        model_reg[a] = x & 'hff;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input int a, output byte_type x);
        @(posedge clk);
        addr <= reg_addr_type'(a);
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        x = rdata;
    endtask

    // Counts clocks up to the next tick; a missing tick ends the run.
    task automatic wait_tick(input int i, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (timebase_tick[i] !== 1'b1 && k < 3000);
        if (k >= 3000) begin
            fail_count++;
            $display("ERROR %0t: no timebase tick", $time);
            finish_test();
        end
    endtask

    // Steps a legacy count held as {high byte, low byte} by k events.
    function automatic int model_count(int md, int c, int k, output int of);
        int c13;
        of = 0;
        repeat (k) begin
            if (md == 0) begin
                c13 = (((c >> 8) << 5) | (c & 'h1f)) + 1;
                of  = of | (c13 == 'h2000);
                c13 = c13 & 'h1fff;
                c   = ((c13 >> 5) << 8) | (c13 & 'h1f);
            end else if (md == 1) begin
                of = of | (c == 'hffff);
                c  = (c + 1) & 'hffff;
            end else begin
                of = of | ((c & 'hff) == 'hff);
                c  = ((c & 'hff) == 'hff) ? (c & 'hff00) | (c >> 8) : c + 1;
            end
        end
        return c;
    endfunction

    initial begin
        srst  = 1'b1;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = '0;
        wdata = '0;
        void'($urandom(80454));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 18; a++) begin
            rd_reg(a, d);
            `CHK(d, 0);
        end
        wr_reg(0, $urandom);
        wr_reg(1, $urandom & 'h77);
        wr_reg(16, 'hff);
        wr_reg(17, 'h5a);
        foreach (ra[j]) begin
            rd_reg(ra[j], d);
            `CHK(d, model_reg[ra[j]] & rm[j]);
        end
        wr_reg(16, 0);
        $display("test registers done");
        for (int t = 0; t < 2; t++) begin
            for (int md = 0; md < 3; md++) begin
                r = $urandom % 3;
                n = 3 + $urandom % 4;
                v = ((md == 2 ? 'ha5 : 'hff) << 8) | ((md == 0 ? 'h1f : 'hff) - r);
                // System clock is selected on purpose: counting must ignore it.
                wr_reg(0, 'h0c);
                wr_reg(1, (md | 4) << (4 * t));
                wr_reg(3 + 2 * t, v & 'hff);
                wr_reg(4 + 2 * t, v >> 8);
                wr_reg(15, 'hff);
                wr_reg(2, 1 << t);
                ev_i.pulse(t, n);
                repeat (6) @(posedge clk);
                wr_reg(2, 0);
                e = model_count(md, v, n, ovf);
                rd_reg(3 + 2 * t, lo);
                rd_reg(4 + 2 * t, hi);
                `CHK({hi, md == 0 ? lo & 8'h1f : lo}, e);
                rd_reg(15, d);
                `CHK(d[t], ovf);
            end
        end
        $display("test event counting done");
        repeat (2) @(posedge clk);
        `CHK(irq, 0);
        wr_reg(16, 2);
        repeat (2) @(posedge clk);
        `CHK(irq, 1);
        wr_reg(15, 2);
        repeat (2) @(posedge clk);
        `CHK(irq, 0);
        rd_reg(15, d);
        `CHK(d, 0);
        wr_reg(16, 0);
        $display("test interrupt done");
        // Split timer 0: its high byte takes run bit 1, so timer 1 counts but may not flag.
        n = 20 + $urandom % 40;
        wr_reg(0, 'h0c);
        wr_reg(1, 'h13);
        foreach (sinit[k]) begin
            wr_reg(3 + k, sinit[k]);
        end
        wr_reg(15, 'hff);
        wr_reg(2, 3);
        repeat (n) @(posedge clk);
        wr_reg(2, 0);
        for (int k = 0; k < 4; k++) begin
            rd_reg(3 + k, d);
            `CHK(d, (sinit[k] + (k == 3 ? (sinit[2] + n + 2) >> 8 : n + 2)) & 'hff);
        end
        rd_reg(15, d);
        `CHK(d, 1);
        $display("test split timer done");
        wr_reg(1, 1);
        foreach (pdiv[c]) begin
            wr_reg(0, c == 4 ? 4 : c);
            wr_reg(3, 0);
            wr_reg(4, 0);
            wr_reg(2, 1);
            repeat (958) @(posedge clk);
            wr_reg(2, 0);
            rd_reg(3, lo);
            rd_reg(4, hi);
            e = 960 / pdiv[c];
            `CHK(({hi, lo} >= 16'(e - 2)) && ({hi, lo} <= 16'(e + 2)), 1);
        end
        $display("test prescaler done");
        foreach (tdiv[s]) begin
            for (int i = 0; i < 2; i++) begin
                wr_reg(2, 0);
                wr_reg(0, s == 0 ? 1 << (4 + 2 * i) : s == 3 ? 3 << (4 + 2 * i) : 0);
                for (int k = 0; k < 4; k++)
                    wr_reg(7 + 4 * i + k, (k % 2 == 1 && s != 3) ? 'hff : 'hf0);
                wr_reg(15, 'hff);
                wr_reg(2, (1 << (2 + i)) | (s == 3 ? 1 << (4 + i) : 0)
                          | (s == 2 ? 1 << (6 + i) : 0));
                wait_tick(i, n);
                wait_tick(i, n);
                `CHK(n, 16 * tdiv[s]);
                rd_reg(15, d);
                `CHK(d, (s == 3 ? 3 : 2) << (2 + 2 * i));
            end
        end
        wr_reg(2, 0);
        $display("test reload timers done");
        finish_test();
    end
endmodule
